/* design/vrs_defs.svh */
// Constants for the reference sequencer: timing counts, codes and setpoint units
`ifndef VRS_DEFS_SVH
`define VRS_DEFS_SVH
`define VRS_CLK_NS        50
`define VRS_SW_PERIOD_NS  4500
`define VRS_SW_CLKS       (`VRS_SW_PERIOD_NS / `VRS_CLK_NS)
`define VRS_FIVE_SAMPLES  13'h004
`define VRS_SIX_SAMPLES   13'h006
`define VRS_FIVE_STABLE   4'hc
`define VRS_FIVE_STEP_END 2'h3
`define VRS_SIX_READS     2'h3
`define VRS_SS_LAST       4'hf
`define VRS_OFF5          5'h1f
`define VRS_CODE_OFF      6'h3f
`define VRS_BASE_LOW      8'h7c
`define VRS_BASE_HIGH     8'h94
`define VRS_SIX_WRAP      6'h14
`define VRS_SIX_BASE_A    8'h57
`define VRS_SIX_BASE_B    8'h95
`define VRS_OV_FIXED_A    8'h84
`define VRS_OV_FIXED_B    8'h9c
`define VRS_OV_MARGIN     8'h10
`endif

/* design/vrs_pkg.sv */
// Types shared by the reference sequencer
package vrs_pkg;
    typedef enum logic [1:0] {VRS_FIVE_LOW, VRS_FIVE_HIGH, VRS_SIX} vrs_mode_e;
    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RAMP, ST_RUN} vrs_state_e;
    typedef struct packed {
        logic lowOe;
        logic lowClamp;
        logic pwmEnable;
    } vrs_gate_s;
    typedef logic [7:0] vrs_units_t;
endpackage

/* design/vrs_sequencer.sv */
// Voltage-select decode, start-up sequencing and overvoltage clamp control
`timescale 1ns/1ps
`include "vrs_defs.svh"

module vrs_sequencer import vrs_pkg::*; #(
    parameter int SW_CLKS = `VRS_SW_CLKS
) (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic [1:0] tableMode,
    input  wire logic       voltSelectBit0,
    input  wire logic       voltSelectBit1,
    input  wire logic       voltSelectBit2,
    input  wire logic       voltSelectBit3,
    input  wire logic       voltSelectBit4,
    input  wire logic       voltSelectExtraBit,
    input  wire logic       porBiasOk,
    input  wire logic       driverSupplyOk,
    input  wire logic       thresholdEnableInput,
    input  wire logic       feedbackAboveRef,
    input  wire logic       overvoltageGuardTrip,
    input  wire logic       overvoltageGuardBelowHyst,
    output vrs_units_t      referenceSetpoint,
    output vrs_units_t      overvoltageThreshold,
    output vrs_gate_s       lowSideGate,
    output logic            overvoltageActive
);

    if (SW_CLKS < 6 || SW_CLKS > 4096) begin : g_chk
        $error("SW_CLKS must lie in 6..4096");
    end

    function automatic logic [13:0] fracStep(input logic [12:0] acc, input logic [12:0] inc);
        logic [12:0] sum;
        sum = acc + inc;
        if (sum >= 13'(SW_CLKS)) begin
            fracStep = {1'b1, 13'(sum - 13'(SW_CLKS))};
        end else begin
            fracStep = {1'b0, sum};
        end
    endfunction

    function automatic vrs_units_t decode(input vrs_mode_e m, input logic [5:0] c);
        decode = 8'h00;
        if (c[5:1] != `VRS_OFF5) begin
            case (m)
                VRS_FIVE_LOW:  decode = `VRS_BASE_LOW - {2'b00, c[5:1], 1'b0};
                VRS_FIVE_HIGH: decode = `VRS_BASE_HIGH - {2'b00, c[5:1], 1'b0};
                default: begin
                    if (c <= `VRS_SIX_WRAP) begin
                        decode = `VRS_SIX_BASE_A - {2'b00, c};
                    end else begin
                        decode = `VRS_SIX_BASE_B - {2'b00, c};
                    end
                end
            endcase
        end
    endfunction

    // Every pin passes two flops; the first is read by the second only
    logic [13:0] syncA_reg;
    logic [13:0] syncB_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            syncA_reg <= 14'h0000;
            syncB_reg <= 14'h0000;
        end else begin
            syncA_reg <= {tableMode, voltSelectBit4, voltSelectBit3, voltSelectBit2,
                          voltSelectBit1, voltSelectBit0, voltSelectExtraBit, porBiasOk,
                          driverSupplyOk, thresholdEnableInput, feedbackAboveRef,
                          overvoltageGuardTrip, overvoltageGuardBelowHyst};
            syncB_reg <= syncA_reg;
        end
    end

    vrs_mode_e   mode;
    logic [5:0]  selNow;
    logic        porBoth;
    logic        enIn;
    logic        fbAbove;
    logic        ovTrip;
    logic        ovLow;
    assign mode    = vrs_mode_e'(syncB_reg[13:12]);
    assign selNow  = syncB_reg[11:6];
    assign porBoth = syncB_reg[5] & syncB_reg[4];
    assign enIn    = syncB_reg[3];
    assign fbAbove = syncB_reg[2];
    assign ovTrip  = syncB_reg[1];
    assign ovLow   = syncB_reg[0];

    // Switching-cycle strobe and fractional sample strobes
    logic [12:0] swCnt_reg;
    logic        cycStb_reg;
    logic [12:0] acc4_reg;
    logic [12:0] acc6_reg;
    logic        stb4_reg;
    logic        stb6_reg;
    logic [13:0] step4;
    logic [13:0] step6;
    assign step4 = fracStep(acc4_reg, `VRS_FIVE_SAMPLES);
    assign step6 = fracStep(acc6_reg, `VRS_SIX_SAMPLES);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            swCnt_reg  <= 13'h0000;
            cycStb_reg <= 1'b0;
            acc4_reg   <= 13'h0000;
            acc6_reg   <= 13'h0000;
            stb4_reg   <= 1'b0;
            stb6_reg   <= 1'b0;
        end else begin
            cycStb_reg <= (swCnt_reg == 13'(SW_CLKS - 1));
            swCnt_reg  <= (swCnt_reg == 13'(SW_CLKS - 1)) ? 13'h0000 : swCnt_reg + 13'h0001;
            acc4_reg   <= step4[12:0];
            stb4_reg   <= step4[13];
            acc6_reg   <= step6[12:0];
            stb6_reg   <= step6[13];
        end
    end

    logic       sixMode;
    assign sixMode = (mode != VRS_FIVE_LOW) && (mode != VRS_FIVE_HIGH);

    // Five-bit debounce: code must hold for a number of whole cycles
    logic [4:0] cand_reg;
    logic [3:0] stable_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cand_reg   <= `VRS_OFF5;
            stable_reg <= 4'h0;
        end else if (stb4_reg && selNow[5:1] != cand_reg) begin
            cand_reg   <= selNow[5:1];
            stable_reg <= 4'h0;
        end else if (cycStb_reg && stable_reg < `VRS_FIVE_STABLE) begin
            stable_reg <= stable_reg + 4'h1;
        end
    end

    // Six-bit debounce: consecutive equal readings
    logic [5:0] read_reg;
    logic [1:0] reads_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            read_reg  <= `VRS_CODE_OFF;
            reads_reg <= 2'h0;
        end else if (stb6_reg) begin
            if (selNow != read_reg) begin
                read_reg  <= selNow;
                reads_reg <= 2'h1;
            end else if (reads_reg < `VRS_SIX_READS) begin
                reads_reg <= reads_reg + 2'h1;
            end
        end
    end

    logic [5:0] acc_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            acc_reg <= `VRS_CODE_OFF;
        end else if (sixMode) begin
            if (reads_reg == `VRS_SIX_READS) begin
                acc_reg <= read_reg;
            end
        end else if (stable_reg == `VRS_FIVE_STABLE) begin
            acc_reg <= {cand_reg, 1'b0};
        end
    end

    logic noLoad;
    logic enable;
    assign noLoad = (acc_reg[5:1] == `VRS_OFF5);
    assign enable = porBoth && enIn && !noLoad;

    vrs_state_e state_reg;

    // Code in force; outside ST_IDLE, five-bit modes walk one table step at a time
    logic [5:0] cur_reg;
    logic [1:0] stepCnt_reg;
    logic       stepStb;
    assign stepStb = cycStb_reg && (stepCnt_reg == `VRS_FIVE_STEP_END);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cur_reg     <= `VRS_CODE_OFF;
            stepCnt_reg <= 2'h0;
        end else if (sixMode || state_reg == ST_IDLE) begin
            cur_reg     <= acc_reg;
            stepCnt_reg <= 2'h0;
        end else if (cycStb_reg) begin
            stepCnt_reg <= stepCnt_reg + 2'h1;
            if (stepStb && cur_reg[5:1] != acc_reg[5:1]) begin
                cur_reg <= (cur_reg[5:1] < acc_reg[5:1]) ? {cur_reg[5:1] + 5'h01, 1'b0}
                                                         : {cur_reg[5:1] - 5'h01, 1'b0};
            end
        end
    end

    vrs_units_t setUnits;
    assign setUnits = decode(mode, cur_reg);

    // Start-up sequence
    logic [3:0] ssCnt_reg;
    vrs_units_t ramp_reg;
    logic       drvOn_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            ssCnt_reg <= 4'h0;
            ramp_reg  <= 8'h00;
            drvOn_reg <= 1'b0;
        end else if (!enable) begin
            state_reg <= ST_IDLE;
            ssCnt_reg <= 4'h0;
            ramp_reg  <= 8'h00;
            drvOn_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_reg <= ST_DELAY;
                    ssCnt_reg <= 4'h0;
                end
                ST_DELAY: begin
                    if (cycStb_reg) begin
                        ssCnt_reg <= ssCnt_reg + 4'h1;
                        if (ssCnt_reg == `VRS_SS_LAST) begin
                            state_reg <= ST_RAMP;
                        end
                    end
                end
                ST_RAMP: begin
                    if (!fbAbove) begin
                        drvOn_reg <= 1'b1;
                    end
                    if (ramp_reg >= setUnits) begin
                        state_reg <= ST_RUN;
                        drvOn_reg <= 1'b1;
                    end else if (cycStb_reg) begin
                        ssCnt_reg <= ssCnt_reg + 4'h1;
                        if (ssCnt_reg == `VRS_SS_LAST) begin
                            ramp_reg <= ramp_reg + 8'h01;
                        end
                    end
                end
                ST_RUN: drvOn_reg <= 1'b1;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Overvoltage threshold and non-latching clamp
    vrs_units_t fixedThr;
    vrs_units_t trackThr;
    logic       clampNext;
    assign fixedThr  = (mode == VRS_FIVE_HIGH) ? `VRS_OV_FIXED_B : `VRS_OV_FIXED_A;
    assign trackThr  = setUnits + `VRS_OV_MARGIN;
    // Set beats release; no latch so a transient clears by itself
    assign clampNext = porBoth && (ovTrip || (lowSideGate.lowClamp && !ovLow));

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            overvoltageThreshold <= `VRS_OV_FIXED_A;
            referenceSetpoint    <= 8'h00;
        end else begin
            case (state_reg)
                ST_DELAY, ST_RAMP: begin
                    overvoltageThreshold <= (trackThr > fixedThr) ? trackThr : fixedThr;
                    referenceSetpoint    <= ramp_reg;
                end
                ST_RUN: begin
                    overvoltageThreshold <= trackThr;
                    referenceSetpoint    <= setUnits;
                end
                default: begin
                    overvoltageThreshold <= fixedThr;
                    referenceSetpoint    <= setUnits;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lowSideGate       <= '0;
            overvoltageActive <= 1'b0;
        end else begin
            lowSideGate.lowOe     <= syncB_reg[5];
            lowSideGate.lowClamp  <= clampNext;
            lowSideGate.pwmEnable <= drvOn_reg && enable && !clampNext;
            overvoltageActive     <= clampNext;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_ramp_done;
        state_reg == ST_RAMP ##1 state_reg == ST_RUN;
    endsequence

    property p_bias_hiz;
        !syncB_reg[5] |=> !lowSideGate.lowOe;
    endproperty
    a_bias_hiz: assert property (p_bias_hiz) else $error("low gate driven below bias");

    property p_supply_off;
        !porBoth |=> !lowSideGate.pwmEnable && !lowSideGate.lowClamp;
    endproperty
    a_supply_off: assert property (p_supply_off) else $error("switch on before supplies");

    property p_clamp_on;
        porBoth && ovTrip |=> lowSideGate.lowClamp && overvoltageActive;
    endproperty
    a_clamp_on: assert property (p_clamp_on) else $error("overvoltage clamp missing");

    property p_clamp_hold;
        lowSideGate.lowClamp && porBoth && !ovLow |=> lowSideGate.lowClamp;
    endproperty
    a_clamp_hold: assert property (p_clamp_hold) else $error("clamp dropped early");

    property p_noload;
        noLoad |=> state_reg == ST_IDLE ##1 !lowSideGate.pwmEnable;
    endproperty
    a_noload: assert property (p_noload) else $error("ran on no-load code");

    property p_start;
        state_reg == ST_IDLE && enable |=> state_reg == ST_DELAY;
    endproperty
    a_start: assert property (p_start) else $error("start-up not immediate");

    property p_ramp_rate;
        state_reg == ST_RAMP && enable && $changed(ramp_reg) |-> $past(cycStb_reg)
            && $past(ssCnt_reg) == `VRS_SS_LAST && ramp_reg == $past(ramp_reg) + 8'h01;
    endproperty
    a_ramp_rate: assert property (p_ramp_rate) else $error("ramp step wrong");

    property p_run_thr;
        state_reg == ST_RUN |=> overvoltageThreshold == $past(setUnits) + `VRS_OV_MARGIN;
    endproperty
    a_run_thr: assert property (p_run_thr) else $error("run threshold wrong");

    property p_ramp_end;
        s_ramp_done ##0 enable && !clampNext |=> lowSideGate.pwmEnable;
    endproperty
    a_ramp_end: assert property (p_ramp_end) else $error("drives not on at ramp end");

    property p_precharge;
        state_reg == ST_RAMP && !drvOn_reg && fbAbove && ramp_reg < setUnits
            |=> !lowSideGate.pwmEnable;
    endproperty
    a_precharge: assert property (p_precharge) else $error("drove into precharge");

    property p_five_step;
        !sixMode && state_reg != ST_IDLE && $changed(cur_reg) && $past(state_reg) != ST_IDLE
            |-> $past(stepStb);
    endproperty
    a_five_step: assert property (p_five_step) else $error("five-bit step off strobe");

    property p_six_load;
        sixMode && reads_reg == `VRS_SIX_READS |=> acc_reg == $past(read_reg);
    endproperty
    a_six_load: assert property (p_six_load) else $error("six-bit code not loaded");

endmodule

/* sim/vrs_cpu_model.sv */
// Processor-side model that drives the six select lines
`timescale 1ns/1ps

module vrs_cpu_model (
    input  wire logic       core_clk,
    input  wire logic       sixBit,
    input  wire logic [5:0] targetCode,
    input  wire logic       glitchOn,
    input  wire logic [5:0] glitchCode,
    output logic      [5:0] selCode
);
    logic [5:0] walkCode;
    logic [5:0] want;

    function automatic int u6(logic [5:0] c);
        if (c > 6'h3d) return 0;
        return (c <= 6'h14) ? 87 - c : 149 - c;
    endfunction

    // A forced code lets the bench probe the reading filter
    assign selCode = glitchOn ? glitchCode : walkCode;

    // In six-bit mode walks one entry at a time except to/from no-load codes, spaced well past the reading filter; five-bit mode jumps straight to the code
    initial begin
        walkCode = 6'h3f;
        forever begin
            @(posedge core_clk);
            want = targetCode;
            #2;
            if (walkCode !== want) begin
                if (!sixBit || u6(want) == 0 || u6(walkCode) == 0)
                    walkCode = want;
                else if (u6(want) > u6(walkCode))
                    walkCode = (walkCode == 6'h00) ? 6'h3d : walkCode - 6'h01;
                else
                    walkCode = (walkCode == 6'h3d) ? 6'h00 : walkCode + 6'h01;
                repeat (20) @(posedge core_clk);
            end
        end
    end
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the reference sequencer
`timescale 1ns/1ps

module tb_top;
    import vrs_pkg::*;
    // Short switching cycle keeps the long ramps affordable
    localparam int SW = 12;
    logic       core_clk, rstn, porBiasOk, driverSupplyOk, thresholdEnableInput;
    logic       feedbackAboveRef, overvoltageGuardTrip, overvoltageGuardBelowHyst;
    logic [1:0] tableMode;
    logic [5:0] selCode;
    logic [5:0] targetCode;
    logic [5:0] glitchCode;
    logic       glitchOn;
    vrs_units_t referenceSetpoint;
    vrs_units_t overvoltageThreshold;
    vrs_gate_s  lowSideGate;
    logic       overvoltageActive;
    int         failures, check_count, n;

    vrs_sequencer #(.SW_CLKS(SW)) uut (
        .core_clk(core_clk), .rstn(rstn), .tableMode(tableMode),
        .voltSelectBit0(selCode[1]), .voltSelectBit1(selCode[2]),
        .voltSelectBit2(selCode[3]), .voltSelectBit3(selCode[4]),
        .voltSelectBit4(selCode[5]), .voltSelectExtraBit(selCode[0]),
        .porBiasOk(porBiasOk), .driverSupplyOk(driverSupplyOk),
        .thresholdEnableInput(thresholdEnableInput), .feedbackAboveRef(feedbackAboveRef),
        .overvoltageGuardTrip(overvoltageGuardTrip),
        .overvoltageGuardBelowHyst(overvoltageGuardBelowHyst),
        .referenceSetpoint(referenceSetpoint), .overvoltageThreshold(overvoltageThreshold),
        .lowSideGate(lowSideGate), .overvoltageActive(overvoltageActive)
    );

    vrs_cpu_model cpu (
        .core_clk(core_clk), .sixBit(tableMode[1]), .targetCode(targetCode),
        .glitchOn(glitchOn), .glitchCode(glitchCode), .selCode(selCode)
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    function automatic vrs_units_t expU(logic [1:0] m, logic [5:0] c);
        int v;
        if (m >= 2'h2) v = (c > 6'h3d) ? 0 : (c <= 6'h14) ? 87 - c : 149 - c;
        else v = (c[5:1] == 5'h1f) ? 0 : ((m == 2'h1) ? 88 : 64) + 2 * (30 - int'(c[5:1]));
        return v[7:0];
    endfunction

    task automatic chkU(vrs_units_t got, vrs_units_t exp, string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t ns: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    task automatic chkB(logic got, logic exp, string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t ns: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic cyc(int k);
        repeat (k) @(posedge core_clk);
        #2;
    endtask

    task automatic wait_ref(vrs_units_t v, int lim);
        n = 0;
        while (referenceSetpoint !== v && n < lim) begin
            cyc(1);
            n++;
        end
    endtask

    // Hands the code to the processor model and waits until the pins show it
    task automatic move_to(logic [5:0] target);
        int k;
        targetCode = target;
        k = 0;
        do begin
            cyc(1);
            k++;
        end while (selCode !== target && k < 400);
        chkB(selCode === target, 1'b1, "processor code walk");
        cyc(20);
    endtask

    task automatic glitch(logic [5:0] c, int k);
        glitchCode = c;
        glitchOn = 1'b1;
        cyc(k);
        glitchOn = 1'b0;
    endtask

    task automatic do_reset(logic [1:0] m);
        rstn = 1'b0;
        tableMode = m;
        thresholdEnableInput = 1'b0;
        feedbackAboveRef = 1'b1;
        overvoltageGuardTrip = 1'b0;
        overvoltageGuardBelowHyst = 1'b1;
        porBiasOk = 1'b1;
        driverSupplyOk = 1'b1;
        cyc(10);
        chkU(overvoltageThreshold, 8'h84, "threshold in reset");
        chkU({5'h00, lowSideGate}, 8'h00, "gates in reset");
        rstn = 1'b1;
        cyc(4);
    endtask

    task automatic t_high();
        logic [5:0] codes [2] = '{6'h3c, 6'h00};
        do_reset(2'h1);
        chkU(overvoltageThreshold, 8'h9c, "fixed threshold high table");
        thresholdEnableInput = 1'b1;
        cyc(34 * SW);
        chkU(referenceSetpoint, 8'h00, "no start on no-load code");
        thresholdEnableInput = 1'b0;
        foreach (codes[i]) begin
            move_to(codes[i]);
            cyc(300);
            chkU(referenceSetpoint, expU(2'h1, codes[i]), "high table decode");
        end
        driverSupplyOk = 1'b0;
        thresholdEnableInput = 1'b1;
        cyc(34 * SW);
        chkU(referenceSetpoint, 8'h94, "no start without driver supply");
        chkB(lowSideGate.pwmEnable, 1'b0, "drives off without supply");
        driverSupplyOk = 1'b1;
        wait_ref(8'h01, 40 * SW);
        chkU(referenceSetpoint, 8'h01, "start once all conditions met");
        $display("test high table done");
    endtask

    task automatic t_low();
        logic [5:0] codes [2] = '{6'h00, 6'h3c};
        do_reset(2'h0);
        porBiasOk = 1'b0;
        cyc(4);
        chkB(lowSideGate.lowOe, 1'b0, "low gates floating below bias");
        porBiasOk = 1'b1;
        cyc(4);
        chkB(lowSideGate.lowOe, 1'b1, "low gates driven");
        foreach (codes[i]) begin
            move_to(codes[i]);
            cyc(300);
            chkU(referenceSetpoint, expU(2'h0, codes[i]), "low table decode");
        end
        chkU(overvoltageThreshold, 8'h84, "fixed threshold low table");
        thresholdEnableInput = 1'b1;
        wait_ref(8'h01, 40 * SW);
        chkB(n >= 16 * SW && n <= 32 * SW + 8, 1'b1, "delay before ramp");
        chkB(lowSideGate.pwmEnable, 1'b0, "drives held while precharged");
        chkU(overvoltageThreshold, 8'h84, "soft-start threshold");
        wait_ref(8'h02, 20 * SW);
        chkB(n == 16 * SW, 1'b1, "ramp step spacing");
        wait_ref(8'h40, 70 * 16 * SW);
        cyc(4);
        chkB(lowSideGate.pwmEnable, 1'b1, "drives at ramp end");
        chkU(overvoltageThreshold, 8'h50, "run threshold");
        // Trip twice: the clamp must never latch the controller off
        for (int i = 0; i < 2; i++) begin
            overvoltageGuardTrip = 1'b1;
            overvoltageGuardBelowHyst = 1'b0;
            cyc(4);
            chkB(lowSideGate.lowClamp, 1'b1, "clamp on trip");
            chkB(overvoltageActive, 1'b1, "clamp status");
            chkB(lowSideGate.pwmEnable, 1'b0, "drives off in clamp");
            overvoltageGuardTrip = 1'b0;
            cyc(10);
            chkB(lowSideGate.lowClamp, 1'b1, "clamp held above hysteresis");
            overvoltageGuardBelowHyst = 1'b1;
            cyc(4);
            chkB(overvoltageActive, 1'b0, "clamp released");
            chkB(lowSideGate.pwmEnable, 1'b1, "drives resume");
        end
        move_to(6'h38);
        cyc(10 * SW);
        chkU(referenceSetpoint, 8'h40, "code not yet accepted");
        wait_ref(8'h42, 8 * SW);
        chkU(referenceSetpoint, 8'h42, "first dynamic step");
        wait_ref(8'h44, 8 * SW);
        chkB(n == 4 * SW, 1'b1, "dynamic step spacing");
        cyc(4);
        chkU(overvoltageThreshold, 8'h54, "threshold follows setpoint");
        glitch(6'h30, 5 * SW);
        cyc(20 * SW);
        chkU(referenceSetpoint, 8'h44, "short code change ignored");
        move_to(6'h3e);
        cyc(16 * SW);
        chkB(lowSideGate.pwmEnable, 1'b0, "no-load code disables");
        move_to(6'h3c);
        wait_ref(8'h01, 60 * SW);
        chkU(referenceSetpoint, 8'h01, "restart after no-load");
        $display("test low table done");
    endtask

    task automatic t_six();
        do_reset(2'h2);
        move_to(6'h00);
        cyc(40);
        chkU(referenceSetpoint, 8'h57, "six-bit decode");
        thresholdEnableInput = 1'b1;
        wait_ref(8'h02, 50 * SW);
        feedbackAboveRef = 1'b0;
        cyc(4);
        chkB(lowSideGate.pwmEnable, 1'b1, "drives once ramp passes feedback");
        wait_ref(8'h57, 90 * 16 * SW);
        chkU(referenceSetpoint, 8'h57, "ramp reaches setpoint");
        move_to(6'h3d);
        chkU(referenceSetpoint, 8'h58, "wrap step loaded at once");
        move_to(6'h3c);
        chkU(referenceSetpoint, 8'h59, "next step loaded");
        glitch(6'h3b, 1);
        cyc(20);
        chkU(referenceSetpoint, 8'h59, "single reading ignored");
        chkU(overvoltageThreshold, 8'h69, "six-bit run threshold");
        do_reset(2'h3);
        cyc(40);
        chkU(referenceSetpoint, 8'h59, "mode three decodes six-bit");
        $display("test six-bit table done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        failures = 0;
        check_count = 0;
        n = 0;
        targetCode = 6'h3f;
        glitchCode = 6'h3f;
        glitchOn = 1'b0;
        t_high();
        t_low();
        t_six();
        give_verdict();
    end

    initial begin
        #(80000 * 50);
        failures++;
        give_verdict();
    end
endmodule
